// file: rtl/leaf_pkg.sv
/*
 * shared constants and types for the enclave leaf execution block.
 * assumes a 32-bit ahb-lite register bus and 4 KiB protected pages.
 */
package leaf_pkg;
   // ****************************************
   // register offsets
   // ****************************************
   localparam logic [7:0] OFF_LEAF     = 8'h00;
   localparam logic [7:0] OFF_CAP      = 8'h04;
   localparam logic [7:0] OFF_TARGET   = 8'h08;
   localparam logic [7:0] OFF_PARENT   = 8'h0c;
   localparam logic [7:0] OFF_CTXPTR   = 8'h10;
   localparam logic [7:0] OFF_MODE     = 8'h14;
   localparam logic [7:0] OFF_DSLIMIT  = 8'h18;
   localparam logic [7:0] OFF_RESULT   = 8'h1c;
   localparam logic [7:0] OFF_STATUS   = 8'h20;
   localparam logic [7:0] OFF_META     = 8'h24;
   localparam logic [7:0] OFF_COUNT    = 8'h28;
   localparam logic [7:0] OFF_CONTEXT  = 8'h2c;
   localparam logic [7:0] OFF_CTXDATA  = 8'h30;
   localparam logic [7:0] OFF_FAULT    = 8'h34;
   localparam logic [7:0] OFF_EPCBASE  = 8'h38;
   localparam logic [7:0] OFF_DSBASE   = 8'h3c;
   // ****************************************
   // codes and field positions
   // ****************************************
   localparam logic [7:0]  LEAF_INC       = 8'h01;
   localparam logic [7:0]  LEAF_CTX       = 8'h02;
   localparam int unsigned CAP_CTX_BIT    = 5;
   localparam logic [31:0] RES_OK         = 32'h0000_0000;
   localparam logic [31:0] CONFLICT_CODE  = 32'h0000_0001;
   localparam int unsigned PAGE_SHIFT     = 12;
   localparam logic [31:0] PAGE_LAST      = 32'h0000_0fff;
   localparam logic [31:0] CTX_LAST       = 32'h0000_0007;
   localparam int unsigned CANON_MSB      = 30;
   localparam int unsigned PFEC_ENCL_BIT  = 15;
   localparam int unsigned META_TYPE_LSB  = 1;
   localparam int unsigned META_HOLD_LSB  = 4;
   localparam int unsigned META_PAR_LSB   = 8;
   localparam int unsigned META_IDX_LSB   = 16;
   localparam logic [31:0] EPC_BASE_RST   = 32'h0010_0000;
   localparam logic [31:0] DS_LIMIT_RST   = 32'hffff_ffff;
   localparam logic [1:0]  HOLD_NONE      = 2'h0;
   localparam logic [1:0]  HOLD_EXCL      = 2'h1;
   localparam logic [1:0]  HOLD_CONC      = 2'h2;
   // ****************************************
   // types
   // ****************************************
   typedef enum logic [2:0] {
      control_page_type       = 3'h0,
      regular_page_type       = 3'h1,
      thread_control_page_type = 3'h2,
      trimmed_page_type       = 3'h3,
      shadow_stack_first_type = 3'h4,
      shadow_stack_rest_type  = 3'h5
   } page_type_t;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_EVAL = 2'b01,
      ST_DONE = 2'b11
   } state_t;
   typedef struct packed {
      logic       valid;
      logic [2:0] ptype;
      logic [1:0] hold;
      logic [7:0] parent;
   } meta_t;
   typedef struct packed {
      logic        mode64;
      logic        ds_unusable;
      logic [31:0] ds_base;
      logic [31:0] ds_limit;
      logic [31:0] epc_base;
   } cfg_t;
   typedef struct packed {
      logic [31:0] target;
      logic [31:0] parent;
      logic [31:0] ctxptr;
      logic [31:0] ctxval;
   } opnd_t;
   typedef struct packed {
      logic zf;
      logic cf;
      logic pf;
      logic af;
      logic of;
      logic sf;
   } flags_t;
   typedef struct packed {
      logic        gp;
      logic        pgf;
      logic        ud;
      logic        conflict;
      logic        ok;
      logic [7:0]  idx;
      logic [31:0] faddr;
   } res_t;
endpackage : leaf_pkg

// file: rtl/enclave_leaf_unit.sv
/*
 * child-count increment and context-set leaf execution with its ahb-lite register file.
 * assumes a single ahb-lite master and that hclk is the only clock.
 */
// Design decisions made here: the AHB-Lite register port and the address map.
`timescale 1ns/100ps
// Functional notes
// - leaf code 01h written to the leaf register runs the child-count increment.
// - leaf code 02h runs context-set, only when the capability bit 5 is reported.
// - increment target not 4K aligned gives general protection, error code zero.
// - target outside the protected page cache gives page fault with enclave bit.
// - parent outside the protected page cache gives page fault with enclave bit.
// - target held exclusively by another operation sets zero flag, conflict code, skips update.
// - target metadata entry not valid gives page fault on target.
// - parent resolved from metadata or own address by page type; others fault.
// - resolved parent differing from parent operand gives general protection fault.
// - success increments counter atomically, clears zero flag, result zero.
// - on success or conflict carry, parity, aux, overflow and sign flags clear.
// - 32-bit mode: unusable segment or operand past limit gives general protection.
// - 64-bit mode: non-canonical operand address gives general protection.
// - conflict code means concurrent instruction on same page; zero means success.
// - context-set writes fetched context value into the control page field.
// - creating a control page sets its context field to its own address.
// - context-set faults when parent operand is not a control page.
// - context pointer not 8-byte aligned or parent not page aligned gives general protection.
// - operands use the data segment base only; no override exists.
// - concurrent-family holders never cause a context-set conflict.
module enclave_leaf_unit #(
   parameter int unsigned PAGES       = 16,
   parameter bit          CTX_LEAF_EN = 1'b1
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp
);
   localparam int unsigned IDX_W     = $clog2(PAGES);
   localparam logic [31:0] EPC_BYTES = 32'(PAGES) << leaf_pkg::PAGE_SHIFT;

   // ****************************************
   // state
   // ****************************************
   logic                 wr_pend_reg, wr_pend_next, rd_pend_reg, rd_pend_next;
   logic [7:0]           addr_reg, addr_next;
   logic [31:0]          hrdata_reg, hrdata_next, rd_mux;
   logic                 hready_reg, hready_next;
   leaf_pkg::cfg_t       cfg_reg, cfg_next;
   leaf_pkg::opnd_t      opnd_reg, opnd_next;
   leaf_pkg::flags_t     flags_reg, flags_next;
   leaf_pkg::res_t       res_reg, res_next;
   leaf_pkg::state_t     state_reg, state_next;
   logic [7:0]           leaf_reg, leaf_next, meta_idx_reg, meta_idx_next;
   logic [31:0]          result_reg, result_next, fault_reg, fault_next;
   logic [3:0]           fault_bits_reg, fault_bits_next;
   leaf_pkg::meta_t      meta_mem [PAGES];
   logic [31:0]          count_mem [PAGES];
   logic [31:0]          ctx_mem [PAGES];
   logic                 meta_we;
   logic [IDX_W-1:0]     meta_wi;
   logic [31:0]          lt, lp, lc, tmp_parent;
   leaf_pkg::meta_t      mt, mp;
   logic                 w32;

   // ****************************************
   // address helpers
   // ****************************************
   function automatic logic seg_bad(input logic [31:0] off, input logic [31:0] last,
                                    input logic [31:0] limit);
      logic [32:0] top;
      top = {1'b0, off} + {1'b0, last};
      return top > {1'b0, limit};
   endfunction : seg_bad

   function automatic logic canon_bad(input logic [31:0] a);
      return ~((&a[31:leaf_pkg::CANON_MSB]) | ~(|a[31:leaf_pkg::CANON_MSB]));
   endfunction : canon_bad

   function automatic logic in_epc(input logic [31:0] a, input logic [31:0] base);
      logic [32:0] d;
      d = {1'b0, a} - {1'b0, base};
      return ~d[32] && (d[31:0] < EPC_BYTES);
   endfunction : in_epc

   function automatic logic [IDX_W-1:0] page_idx(input logic [31:0] a, input logic [31:0] base);
      logic [31:0] d;
      d = a - base;
      return d[leaf_pkg::PAGE_SHIFT +: IDX_W];
   endfunction : page_idx

   function automatic logic [31:0] page_addr(input logic [IDX_W-1:0] i, input logic [31:0] base);
      return base + (32'(i) << leaf_pkg::PAGE_SHIFT);
   endfunction : page_addr

   // ****************************************
   // ahb-lite slave
   // ****************************************
   always_comb begin
      logic acc;
      acc          = hsel & htrans[1] & hready;
      wr_pend_next = acc & hwrite;
      rd_pend_next = acc & ~hwrite;
      addr_next    = acc ? haddr[7:0] : addr_reg;
      hready_next  = ~(acc & ~hwrite);
      hrdata_next  = rd_pend_reg ? rd_mux : hrdata_reg;
   end

   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (addr_reg)
         leaf_pkg::OFF_LEAF:    rd_mux = {24'h00_0000, leaf_reg};
         leaf_pkg::OFF_CAP:     rd_mux = 32'(CTX_LEAF_EN) << leaf_pkg::CAP_CTX_BIT;
         leaf_pkg::OFF_TARGET:  rd_mux = opnd_reg.target;
         leaf_pkg::OFF_PARENT:  rd_mux = opnd_reg.parent;
         leaf_pkg::OFF_CTXPTR:  rd_mux = opnd_reg.ctxptr;
         leaf_pkg::OFF_MODE:    rd_mux = {30'h0000_0000, cfg_reg.ds_unusable, cfg_reg.mode64};
         leaf_pkg::OFF_DSLIMIT: rd_mux = cfg_reg.ds_limit;
         leaf_pkg::OFF_RESULT:  rd_mux = result_reg;
         leaf_pkg::OFF_STATUS:  rd_mux = {21'h00_0000, fault_bits_reg, flags_reg, state_reg != leaf_pkg::ST_IDLE};
         leaf_pkg::OFF_META:    rd_mux = {8'h00, meta_idx_reg, meta_mem[meta_idx_reg[IDX_W-1:0]], 2'h0};
         leaf_pkg::OFF_COUNT:   rd_mux = count_mem[meta_idx_reg[IDX_W-1:0]];
         leaf_pkg::OFF_CONTEXT: rd_mux = ctx_mem[meta_idx_reg[IDX_W-1:0]];
         leaf_pkg::OFF_CTXDATA: rd_mux = opnd_reg.ctxval;
         leaf_pkg::OFF_FAULT:   rd_mux = fault_reg;
         leaf_pkg::OFF_EPCBASE: rd_mux = cfg_reg.epc_base;
         leaf_pkg::OFF_DSBASE:  rd_mux = cfg_reg.ds_base;
         default:               rd_mux = 32'h0000_0000;
      endcase
   end

   // ****************************************
   // software-written registers
   // ****************************************
   always_comb begin
      logic wr;
      wr            = wr_pend_reg;
      cfg_next      = cfg_reg;
      opnd_next     = opnd_reg;
      leaf_next     = leaf_reg;
      meta_idx_next = meta_idx_reg;
      meta_we       = 1'b0;
      meta_wi       = hwdata[leaf_pkg::META_IDX_LSB +: IDX_W];
      if (wr) begin
         unique case (addr_reg)
            leaf_pkg::OFF_LEAF:    if (state_reg == leaf_pkg::ST_IDLE) leaf_next = hwdata[7:0];
            leaf_pkg::OFF_TARGET:  opnd_next.target = hwdata;
            leaf_pkg::OFF_PARENT:  opnd_next.parent = hwdata;
            leaf_pkg::OFF_CTXPTR:  opnd_next.ctxptr = hwdata;
            leaf_pkg::OFF_CTXDATA: opnd_next.ctxval = hwdata;
            leaf_pkg::OFF_MODE: begin
               cfg_next.mode64      = hwdata[0];
               cfg_next.ds_unusable = hwdata[1];
            end
            leaf_pkg::OFF_DSLIMIT: cfg_next.ds_limit = hwdata;
            leaf_pkg::OFF_EPCBASE: cfg_next.epc_base = hwdata;
            leaf_pkg::OFF_DSBASE:  cfg_next.ds_base = hwdata;
            leaf_pkg::OFF_META: begin
               meta_we       = 1'b1;
               meta_idx_next = hwdata[leaf_pkg::META_IDX_LSB +: 8];
            end
            default: ;
         endcase
      end
   end

   // ****************************************
   // leaf sequencer and checks
   // ****************************************
   assign w32 = ~cfg_reg.mode64;
   assign lt  = opnd_reg.target + cfg_reg.ds_base;
   assign lp  = opnd_reg.parent + cfg_reg.ds_base;
   assign lc  = opnd_reg.ctxptr + cfg_reg.ds_base;
   assign mt  = meta_mem[page_idx(lt, cfg_reg.epc_base)];
   assign mp  = meta_mem[page_idx(lp, cfg_reg.epc_base)];

   always_comb begin
      tmp_parent = lt;
      unique case (mt.ptype)
         leaf_pkg::regular_page_type, leaf_pkg::thread_control_page_type, leaf_pkg::trimmed_page_type,
         leaf_pkg::shadow_stack_first_type, leaf_pkg::shadow_stack_rest_type:
            tmp_parent = page_addr(mt.parent[IDX_W-1:0], cfg_reg.epc_base);
         default: tmp_parent = lt;
      endcase
   end

   always_comb begin
      state_next = state_reg;
      res_next   = res_reg;
      unique case (state_reg)
         leaf_pkg::ST_IDLE: begin
            if (wr_pend_reg && addr_reg == leaf_pkg::OFF_LEAF) state_next = leaf_pkg::ST_EVAL;
         end
         leaf_pkg::ST_EVAL: begin
            state_next    = leaf_pkg::ST_DONE;
            res_next      = '0;
            res_next.idx  = 8'(page_idx(lp, cfg_reg.epc_base));
            if (leaf_reg == leaf_pkg::LEAF_INC) begin
               if (w32 && (cfg_reg.ds_unusable || seg_bad(opnd_reg.target, leaf_pkg::PAGE_LAST, cfg_reg.ds_limit)
                   || seg_bad(opnd_reg.parent, leaf_pkg::PAGE_LAST, cfg_reg.ds_limit)))
                  res_next.gp = 1'b1;
               else if (cfg_reg.mode64 && (canon_bad(lt) || canon_bad(lp)))
                  res_next.gp = 1'b1;
               else if (lt[11:0] != 12'h000)
                  res_next.gp = 1'b1;
               else if (!in_epc(lt, cfg_reg.epc_base)) begin
                  res_next.pgf   = 1'b1;
                  res_next.faddr = lt;
               end else if (!in_epc(lp, cfg_reg.epc_base)) begin
                  res_next.pgf   = 1'b1;
                  res_next.faddr = lp;
               end else if (mt.hold == leaf_pkg::HOLD_EXCL)
                  res_next.conflict = 1'b1;
               else if (!mt.valid) begin
                  res_next.pgf   = 1'b1;
                  res_next.faddr = lt;
               end else if (mt.ptype > 3'h5) begin
                  res_next.pgf   = 1'b1;
                  res_next.faddr = lt;
               end else if (tmp_parent != lp)
                  res_next.gp = 1'b1;
               else
                  res_next.ok = 1'b1;
            end else if (leaf_reg == leaf_pkg::LEAF_CTX && CTX_LEAF_EN) begin
               if (w32 && (cfg_reg.ds_unusable || seg_bad(opnd_reg.parent, leaf_pkg::PAGE_LAST, cfg_reg.ds_limit)
                   || seg_bad(opnd_reg.ctxptr, leaf_pkg::CTX_LAST, cfg_reg.ds_limit)))
                  res_next.gp = 1'b1;
               else if (cfg_reg.mode64 && (canon_bad(lp) || canon_bad(lc)))
                  res_next.gp = 1'b1;
               else if (lp[11:0] != 12'h000)
                  res_next.gp = 1'b1;
               else if (!in_epc(lp, cfg_reg.epc_base)) begin
                  res_next.pgf   = 1'b1;
                  res_next.faddr = lp;
               end else if (mp.hold == leaf_pkg::HOLD_EXCL)
                  res_next.conflict = 1'b1;
               else if (lc[2:0] != 3'h0)
                  res_next.gp = 1'b1;
               else if (!mp.valid || mp.ptype != leaf_pkg::control_page_type) begin
                  res_next.pgf   = 1'b1;
                  res_next.faddr = lp;
               end else
                  res_next.ok = 1'b1;
            end else
               res_next.ud = 1'b1;
         end
         leaf_pkg::ST_DONE: state_next = leaf_pkg::ST_IDLE;
      endcase
   end

   // ****************************************
   // completion: result, flags, faults
   // ****************************************
   always_comb begin
      result_next     = result_reg;
      flags_next      = flags_reg;
      fault_next      = fault_reg;
      fault_bits_next = fault_bits_reg;
      if (wr_pend_reg && addr_reg == leaf_pkg::OFF_STATUS) flags_next = hwdata[6:1];
      if (state_reg == leaf_pkg::ST_EVAL) fault_bits_next = 4'h0;
      if (state_reg == leaf_pkg::ST_DONE) begin
         if (res_reg.ok || res_reg.conflict) begin
            flags_next    = '0;
            flags_next.zf = res_reg.conflict;
            result_next   = res_reg.conflict ? leaf_pkg::CONFLICT_CODE : leaf_pkg::RES_OK;
         end
         fault_bits_next = {res_reg.ud, res_reg.pgf, res_reg.pgf, res_reg.gp};
         if (res_reg.gp || res_reg.pgf) fault_next = res_reg.faddr;
      end
   end

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg    <= 1'b0;
         rd_pend_reg    <= 1'b0;
         addr_reg       <= 8'h00;
         hrdata_reg     <= 32'h0000_0000;
         hready_reg     <= 1'b1;
         cfg_reg        <= '{mode64: 1'b0, ds_unusable: 1'b0, ds_base: 32'h0000_0000,
                             ds_limit: leaf_pkg::DS_LIMIT_RST, epc_base: leaf_pkg::EPC_BASE_RST};
         opnd_reg       <= '0;
         flags_reg      <= '0;
         res_reg        <= '0;
         state_reg      <= leaf_pkg::ST_IDLE;
         leaf_reg       <= 8'h00;
         meta_idx_reg   <= 8'h00;
         result_reg     <= leaf_pkg::RES_OK;
         fault_reg      <= 32'h0000_0000;
         fault_bits_reg <= 4'h0;
      end else begin
         wr_pend_reg    <= wr_pend_next;
         rd_pend_reg    <= rd_pend_next;
         addr_reg       <= addr_next;
         hrdata_reg     <= hrdata_next;
         hready_reg     <= hready_next;
         cfg_reg        <= cfg_next;
         opnd_reg       <= opnd_next;
         flags_reg      <= flags_next;
         res_reg        <= res_next;
         state_reg      <= state_next;
         leaf_reg       <= leaf_next;
         meta_idx_reg   <= meta_idx_next;
         result_reg     <= result_next;
         fault_reg      <= fault_next;
         fault_bits_reg <= fault_bits_next;
      end
   end

   // ****************************************
   // page metadata and control page fields
   // ****************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < PAGES; i++) begin
            meta_mem[i]  <= '0;
            count_mem[i] <= 32'h0000_0000;
            ctx_mem[i]   <= 32'h0000_0000;
         end
      end else begin
         if (meta_we) begin
            meta_mem[meta_wi] <= {hwdata[0], hwdata[leaf_pkg::META_TYPE_LSB +: 3],
                                  hwdata[leaf_pkg::META_HOLD_LSB +: 2], hwdata[leaf_pkg::META_PAR_LSB +: 8]};
            if (hwdata[0] && hwdata[leaf_pkg::META_TYPE_LSB +: 3] == leaf_pkg::control_page_type) begin
               ctx_mem[meta_wi]   <= page_addr(meta_wi, cfg_reg.epc_base);
               count_mem[meta_wi] <= 32'h0000_0000;
            end
         end
         if (state_reg == leaf_pkg::ST_DONE && res_reg.ok) begin
            if (leaf_reg == leaf_pkg::LEAF_INC)
               count_mem[res_reg.idx[IDX_W-1:0]] <= count_mem[res_reg.idx[IDX_W-1:0]] + 32'h0000_0001;
            else
               ctx_mem[res_reg.idx[IDX_W-1:0]] <= opnd_reg.ctxval;
         end
      end
   end

   assign hrdata    = hrdata_reg;
   assign hreadyout = hready_reg;
   assign hresp     = 1'b0;
endmodule : enclave_leaf_unit

// file: tb/leaf_monitor.sv
/* bus checker for enclave_leaf_unit.
   sees only the top ports; bound in at the foot of this file. */
`timescale 1ns/100ps
module leaf_monitor #(
   parameter bit CTX_LEAF_EN = 1'b1
) (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [2:0]  hsize,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp
);
   // ****************************************
   // bus properties
   // ****************************************
   logic rd_acc;
   logic wr_acc;
   assign rd_acc = hsel && htrans[1] && hready && !hwrite;
   assign wr_acc = hsel && htrans[1] && hready && hwrite;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   resp_okay_a: assert property (hresp == 1'b0) else $error("hresp not okay");
   rd_wait_a: assert property (rd_acc |=> !hreadyout) else $error("read without wait");
   wait_once_a: assert property (!hreadyout |=> hreadyout) else $error("wait too long");
   wait_cause_a: assert property (!hreadyout |-> $past(rd_acc)) else $error("wait without read");
   wr_nowait_a: assert property (wr_acc |=> hreadyout && $stable(hrdata)) else $error("write stalled");
   rdata_hold_a: assert property ($past(hreadyout) |-> $stable(hrdata)) else $error("hrdata moved");
   cap_bit_a:
      assert property (rd_acc && haddr[7:0] == leaf_pkg::OFF_CAP |-> ##2 hrdata[5] == CTX_LEAF_EN)
      else $error("capability bit wrong");
   result_code_a:
      assert property (rd_acc && haddr[7:0] == leaf_pkg::OFF_RESULT |-> ##2
         (hrdata == leaf_pkg::RES_OK || hrdata == leaf_pkg::CONFLICT_CODE)) else $error("bad result code");
   encl_bit_a:
      assert property (rd_acc && haddr[7:0] == leaf_pkg::OFF_STATUS |-> ##2
         (hrdata[9] == hrdata[8] && !(hrdata[8] && hrdata[7]))) else $error("fault bits inconsistent");
   unmapped_zero_a: assert property (rd_acc && haddr[7:0] >= 8'h40 |-> ##2 hrdata == 32'h0)
      else $error("unmapped read not zero");
   leaf_go_c: cover property (wr_acc && haddr[7:0] == leaf_pkg::OFF_LEAF);
   rd_wait_c: cover property (!hreadyout);
   status_c: cover property (rd_acc && haddr[7:0] == leaf_pkg::OFF_STATUS);
endmodule : leaf_monitor
bind enclave_leaf_unit leaf_monitor #(.CTX_LEAF_EN(CTX_LEAF_EN)) mon (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
   .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));

// file: tb/test_enclave_leaf_unit.sv
/* self-checking bench for enclave_leaf_unit.
   the bench is the only ahb-lite master; hready is fed back from hreadyout. */
`timescale 1ns/100ps
module test_enclave_leaf_unit;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic [31:0] rd;
   int          err_count = 0;
   int          num_checks = 0;
   always #20 hclk = ~hclk;
   enclave_leaf_unit dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp));
   // ****************************************
   // bus and check tasks
   // ****************************************
   task end_sim;
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : end_sim
   task give_up;
      err_count++;
      $display("Error %0t: wait timed out", $time);
      end_sim;
   endtask : give_up
   task check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      if (hreadyout !== 1'b1) give_up;
   endtask : wait_rdy
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= w;
      wait_rdy;
      htrans <= 2'b00;
      hwdata <= d;
      wait_rdy;
      rd = hrdata;
   endtask : bus
   task wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr
   task rdc(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      check(rd, exp);
   endtask : rdc
   task run(input logic [7:0] c);
      int n;
      wr(leaf_pkg::OFF_LEAF, {24'h0, c});
      n = 0;
      do begin
         bus(1'b0, leaf_pkg::OFF_STATUS, 32'h0);
         n++;
      end while (rd[0] !== 1'b0 && n < 10);
      if (rd[0] !== 1'b0) give_up;
   endtask : run
   task inc_case(input logic [31:0] m, input logic [31:0] lim, input logic [31:0] t, input logic [31:0] p,
                 input logic [31:0] st);
      wr(leaf_pkg::OFF_MODE, m);
      wr(leaf_pkg::OFF_DSLIMIT, lim);
      wr(leaf_pkg::OFF_TARGET, t);
      wr(leaf_pkg::OFF_PARENT, p);
      run(leaf_pkg::LEAF_INC);
      rdc(leaf_pkg::OFF_STATUS, st);
   endtask : inc_case
   // ****************************************
   // scenarios
   // ****************************************
   task t_regs;
      rdc(leaf_pkg::OFF_EPCBASE, 32'h0010_0000);
      rdc(leaf_pkg::OFF_DSLIMIT, 32'hffff_ffff);
      rdc(leaf_pkg::OFF_CAP, 32'h0000_0020);
      wr(8'h40, 32'hffff_ffff);
      rdc(8'h40, 32'h0);
      run(8'h03);
      rdc(leaf_pkg::OFF_STATUS, 32'h0000_0400);
      $display("test regs done");
   endtask : t_regs
   task t_inc;
      wr(leaf_pkg::OFF_META, 32'h0002_0103);
      wr(leaf_pkg::OFF_META, 32'h0001_0001);
      rdc(leaf_pkg::OFF_CONTEXT, 32'h0010_1000);
      rdc(leaf_pkg::OFF_COUNT, 32'h0);
      wr(leaf_pkg::OFF_STATUS, 32'h0000_007e);
      inc_case(32'h0, 32'hffff_ffff, 32'h0010_2000, 32'h0010_1000, 32'h0);
      rdc(leaf_pkg::OFF_RESULT, leaf_pkg::RES_OK);
      rdc(leaf_pkg::OFF_COUNT, 32'h1);
      inc_case(32'h0, 32'hffff_ffff, 32'h0010_1000, 32'h0010_1000, 32'h0);
      rdc(leaf_pkg::OFF_COUNT, 32'h2);
      $display("test increment done");
   endtask : t_inc
   task t_fault;
      inc_case(32'h0, 32'hffff_ffff, 32'h0010_2004, 32'h0010_1000, 32'h80);
      inc_case(32'h0, 32'hffff_ffff, 32'h0020_0000, 32'h0010_1000, 32'h300);
      rdc(leaf_pkg::OFF_FAULT, 32'h0020_0000);
      inc_case(32'h0, 32'hffff_ffff, 32'h0010_2000, 32'h0030_0000, 32'h300);
      inc_case(32'h0, 32'hffff_ffff, 32'h0010_3000, 32'h0010_1000, 32'h300);
      inc_case(32'h0, 32'hffff_ffff, 32'h0010_2000, 32'h0010_4000, 32'h80);
      wr(leaf_pkg::OFF_META, 32'h0005_000d);
      inc_case(32'h0, 32'hffff_ffff, 32'h0010_5000, 32'h0010_1000, 32'h300);
      inc_case(32'h1, 32'hffff_ffff, 32'h4010_2000, 32'h0010_1000, 32'h80);
      inc_case(32'h2, 32'hffff_ffff, 32'h0010_2000, 32'h0010_1000, 32'h80);
      inc_case(32'h0, 32'h0010_2800, 32'h0010_2000, 32'h0010_1000, 32'h80);
      rdc(leaf_pkg::OFF_RESULT, leaf_pkg::RES_OK);
      wr(leaf_pkg::OFF_DSBASE, 32'h0000_1000);
      inc_case(32'h0, 32'hffff_ffff, 32'h0010_1000, 32'h0010_0000, 32'h0);
      wr(leaf_pkg::OFF_DSBASE, 32'h0);
      $display("test faults done");
   endtask : t_fault
   task t_conf;
      wr(leaf_pkg::OFF_META, 32'h0001_0011);
      wr(leaf_pkg::OFF_STATUS, 32'h0000_007e);
      inc_case(32'h0, 32'hffff_ffff, 32'h0010_1000, 32'h0010_1000, 32'h40);
      rdc(leaf_pkg::OFF_RESULT, leaf_pkg::CONFLICT_CODE);
      rdc(leaf_pkg::OFF_COUNT, 32'h0);
      $display("test conflict done");
   endtask : t_conf
   task t_ctx;
      wr(leaf_pkg::OFF_META, 32'h0001_0021);
      wr(leaf_pkg::OFF_PARENT, 32'h0010_1000);
      wr(leaf_pkg::OFF_CTXPTR, 32'h0000_0100);
      wr(leaf_pkg::OFF_CTXDATA, 32'h1234_5678);
      wr(leaf_pkg::OFF_STATUS, 32'h0000_007e);
      run(leaf_pkg::LEAF_CTX);
      rdc(leaf_pkg::OFF_STATUS, 32'h0);
      rdc(leaf_pkg::OFF_RESULT, leaf_pkg::RES_OK);
      rdc(leaf_pkg::OFF_CONTEXT, 32'h1234_5678);
      wr(leaf_pkg::OFF_CTXPTR, 32'h0000_0104);
      run(leaf_pkg::LEAF_CTX);
      rdc(leaf_pkg::OFF_STATUS, 32'h80);
      rdc(leaf_pkg::OFF_CONTEXT, 32'h1234_5678);
      wr(leaf_pkg::OFF_CTXPTR, 32'h0000_0100);
      wr(leaf_pkg::OFF_PARENT, 32'h0010_1800);
      run(leaf_pkg::LEAF_CTX);
      rdc(leaf_pkg::OFF_STATUS, 32'h80);
      wr(leaf_pkg::OFF_PARENT, 32'h0010_2000);
      run(leaf_pkg::LEAF_CTX);
      rdc(leaf_pkg::OFF_STATUS, 32'h300);
      $display("test context done");
   endtask : t_ctx
   initial begin
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_regs;
      t_inc;
      t_fault;
      t_conf;
      t_ctx;
      end_sim;
   end
endmodule : test_enclave_leaf_unit
